// file: logic/rdiam_est.sv
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps

// Function
// - diameter from line speed over reel speed, as percent of full roll
// - calculation runs only while line speed magnitude exceeds threshold
// - below threshold the raw diameter holds its last calculated value
// - preset select drives the diameter output from the preset value
// - core ratio floor scales the result and bounds its range
// - output slews so a full 100 percent change takes slew time
module rdiam_est import rdiam_pkg::*; (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic             pslverr,
	output logic [31:0]      prdata,
	// speed inputs, signed, from other clock domains
	input  wire logic [15:0] web_velocity_in,
	input  wire logic [15:0] spindle_velocity_in,
	// diameter and monitoring
	output logic [15:0]      roll_size_out,
	output logic [15:0]      roll_size_raw,
	output logic [15:0]      web_velocity_magnitude,
	output logic [15:0]      spindle_velocity_magnitude,
	output logic             calc_active
);

	// ****************************************
	// helpers
	// ****************************************
	// magnitude of a signed speed; -32768 maps to 32768, still fits
	function automatic logic [15:0] mag16(input logic [15:0] v);
		if (v[15]) begin
			return (~v) + 16'h0001;
		end else begin
			return v;
		end
	endfunction

	// register index for an address
	function automatic rdiam_reg_t dec(input logic [7:0] a);
		if (a == A_CTRL) begin
			return RD_CTRL;
		end else if (a == A_THRESH) begin
			return RD_THRESH;
		end else if (a == A_FLOOR) begin
			return RD_FLOOR;
		end else if (a == A_PVAL) begin
			return RD_PVAL;
		end else if (a == A_SLEW) begin
			return RD_SLEW;
		end else if (a == A_OUT) begin
			return RD_OUT;
		end else if (a == A_RAW) begin
			return RD_RAW;
		end else if (a == A_WMAG) begin
			return RD_WMAG;
		end else if (a == A_SMAG) begin
			return RD_SMAG;
		end else begin
			return RD_NONE;
		end
	endfunction

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [15:0] web_s1;
		logic [15:0] web_s2;
		logic [15:0] spin_s1;
		logic [15:0] spin_s2;
		logic [15:0] web_mag;
		logic [15:0] spin_mag;
		logic        active;
		rdiam_cfg_t  cfg;
		logic [15:0] raw;
		logic [15:0] out;
		logic [19:0] tick;
		logic        start;
	} rdiam_state_t;

	rdiam_state_t   s_q, s_d;
	rdiam_apb_req_t req;
	rdiam_reg_t     sel;
	logic           wr_en;
	logic           div_busy;
	logic           div_done;
	logic [31:0]    div_quot;
	logic [31:0]    numer;
	logic [15:0]    result;
	logic [19:0]    period;

	assign req = '{psel: psel, penable: penable, pwrite: pwrite,
		paddr: paddr, pwdata: pwdata};
	assign sel = dec(req.paddr);

	// ****************************************
	// apb slave, zero wait states
	// ****************************************
	// every access completes at once; unmapped addresses flag an error
	assign pready  = 1'b1;
	assign pslverr = req.psel && req.penable && (sel == RD_NONE);
	assign wr_en   = req.psel && req.penable && req.pwrite
		&& (sel != RD_NONE);

	// read mux over flip-flops; upper bits read as zero
	always_comb begin
		prdata = 32'h00000000;
		if (sel == RD_CTRL) begin
			prdata[CTRL_PRESET_BIT] = s_q.cfg.preset;
		end else if (sel == RD_THRESH) begin
			prdata[15:0] = s_q.cfg.thresh;
		end else if (sel == RD_FLOOR) begin
			prdata[15:0] = s_q.cfg.floor;
		end else if (sel == RD_PVAL) begin
			prdata[15:0] = s_q.cfg.pval;
		end else if (sel == RD_SLEW) begin
			prdata[15:0] = s_q.cfg.slew_ms;
		end else if (sel == RD_OUT) begin
			prdata[15:0] = s_q.out;
		end else if (sel == RD_RAW) begin
			prdata[15:0] = s_q.raw;
		end else if (sel == RD_WMAG) begin
			prdata[15:0] = s_q.web_mag;
		end else if (sel == RD_SMAG) begin
			prdata[15:0] = s_q.spin_mag;
		end
	end

	// ****************************************
	// divider
	// ****************************************
	// floor times line over reel: at core size and matched speeds
	// the result equals the floor itself
	assign numer = {16'h0000, s_q.cfg.floor} * {16'h0000, s_q.web_mag};

	rdiam_div u_div (
		.clk   (clk),
		.rst_n (rst_n),
		.start (s_q.start),
		.numer (numer),
		.denom (s_q.spin_mag),
		.busy  (div_busy),
		.done  (div_done),
		.quot  (div_quot)
	);

	// clamp to floor..full; a stalled reel reads as full roll
	always_comb begin
		if (s_q.spin_mag == 16'h0000 || div_quot > {16'h0000, PCT_FULL}) begin
			result = PCT_FULL;
		end else if (div_quot[15:0] < s_q.cfg.floor) begin
			result = s_q.cfg.floor;
		end else begin
			result = div_quot[15:0];
		end
	end

	// cycles per output count; zero slew time moves every cycle
	assign period = s_q.cfg.slew_ms * 20'(STEP_CYC_PER_MS);

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		s_d = s_q;
		// two-flop synchronisers for the speed pins
		s_d.web_s1   = web_velocity_in;
		s_d.web_s2   = s_q.web_s1;
		s_d.spin_s1  = spindle_velocity_in;
		s_d.spin_s2  = s_q.spin_s1;
		s_d.web_mag  = mag16(s_q.web_s2);
		s_d.spin_mag = mag16(s_q.spin_s2);
		s_d.active   = s_q.web_mag > s_q.cfg.thresh;
		// software settings
		if (wr_en) begin
			if (sel == RD_CTRL) begin
				s_d.cfg.preset = req.pwdata[CTRL_PRESET_BIT];
			end else if (sel == RD_THRESH) begin
				s_d.cfg.thresh = req.pwdata[15:0];
			end else if (sel == RD_FLOOR) begin
				s_d.cfg.floor = req.pwdata[15:0];
			end else if (sel == RD_PVAL) begin
				s_d.cfg.pval = req.pwdata[15:0];
			end else if (sel == RD_SLEW) begin
				s_d.cfg.slew_ms = req.pwdata[15:0];
			end
		end
		// launch a division whenever idle and calculating
		s_d.start = !div_busy && !s_q.start && !div_done
			&& s_q.active && !s_q.cfg.preset;
		// late results are dropped once the line slows: hold value
		if (s_q.cfg.preset) begin
			s_d.raw  = s_q.cfg.pval;
			s_d.out  = s_q.cfg.pval;
			s_d.tick = 20'h00000;
		end else begin
			if (div_done && s_q.active) begin
				s_d.raw = result;
			end
			// rate limiter, one count per period
			if (s_q.out == s_q.raw) begin
				s_d.tick = 20'h00000;
			end else if (s_q.tick + 20'h00001 >= period) begin
				s_d.tick = 20'h00000;
				if (s_q.out < s_q.raw) begin
					s_d.out = s_q.out + 16'h0001;
				end else begin
					s_d.out = s_q.out - 16'h0001;
				end
			end else begin
				s_d.tick = s_q.tick + 20'h00001;
			end
		end
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_q             <= '0;
			s_q.cfg.preset  <= PRESET_RST;
			s_q.cfg.thresh  <= THRESH_RST;
			s_q.cfg.floor   <= FLOOR_RST;
			s_q.cfg.pval    <= PVAL_RST;
			s_q.cfg.slew_ms <= SLEW_MS_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign roll_size_out              = s_q.out;
	assign roll_size_raw              = s_q.raw;
	assign web_velocity_magnitude     = s_q.web_mag;
	assign spindle_velocity_magnitude = s_q.spin_mag;
	assign calc_active                = s_q.active;

	// ****************************************
	// checks
	// ****************************************
	property p_active;
		@(posedge clk) disable iff (!rst_n)
		##1 calc_active == ($past(s_q.web_mag) > $past(s_q.cfg.thresh));
	endproperty
	a_active: assert property (p_active)
		else $error("activation does not follow threshold");

	property p_hold;
		@(posedge clk) disable iff (!rst_n)
		(!s_q.active && !s_q.cfg.preset && !s_d.cfg.preset)
			|=> $stable(roll_size_raw);
	endproperty
	a_hold: assert property (p_hold)
		else $error("raw diameter moved while inactive");

	property p_preset;
		@(posedge clk) disable iff (!rst_n)
		s_q.cfg.preset |=> (roll_size_out == $past(s_q.cfg.pval));
	endproperty
	a_preset: assert property (p_preset)
		else $error("preset value not on output");

	property p_range;
		@(posedge clk) disable iff (!rst_n)
		(div_done && s_q.active && !s_q.cfg.preset) |=>
			(roll_size_raw >= $past(s_q.cfg.floor)
			&& roll_size_raw <= PCT_FULL);
	endproperty
	a_range: assert property (p_range)
		else $error("raw diameter out of range");

	property p_slew_step;
		@(posedge clk) disable iff (!rst_n)
		!s_q.cfg.preset |=> (roll_size_out == $past(roll_size_out)
			|| roll_size_out == $past(roll_size_out) + 16'h0001
			|| roll_size_out == $past(roll_size_out) - 16'h0001);
	endproperty
	a_slew_step: assert property (p_slew_step)
		else $error("output moved more than one count");

	property p_slew_pace;
		@(posedge clk) disable iff (!rst_n)
		(!s_q.cfg.preset && s_q.tick != 20'h00000)
			|-> $stable(roll_size_out);
	endproperty
	a_slew_pace: assert property (p_slew_pace)
		else $error("output moved mid period");

	sequence s_pin_in;
		##3 web_velocity_magnitude == mag16($past(web_velocity_in, 3));
	endsequence
	property p_mag;
		@(posedge clk) disable iff (!rst_n)
		1'b1 |-> s_pin_in;
	endproperty
	a_mag: assert property (p_mag)
		else $error("line speed magnitude wrong");

	property p_unmapped;
		@(posedge clk) disable iff (!rst_n)
		(psel && penable && dec(paddr) == RD_NONE)
			|-> (pslverr && pready && prdata == 32'h00000000);
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped access not flagged");

endmodule

// file: logic/rdiam_pkg.sv
package rdiam_pkg;

	// ****************************************
	// numbers: hundredths of a percent
	// ****************************************
	localparam int          CLK_HZ         = 50_000_000;
	localparam logic [15:0] PCT_FULL       = 16'h2710; // 100.00 %
	localparam logic [15:0] THRESH_RST     = 16'h01F4; // 5.00 %
	localparam logic [15:0] FLOOR_RST      = 16'h03E8; // 10.00 %
	localparam logic [15:0] PVAL_RST       = 16'h0000;
	localparam logic [15:0] SLEW_MS_RST    = 16'h1388; // 5000 ms = 5.0 s
	localparam logic        PRESET_RST     = 1'b0;
	// clock cycles per output count, per millisecond of slew time
	localparam int          STEP_CYC_PER_MS = CLK_HZ / 1000 / 10000;

	// ****************************************
	// register map, byte addresses
	// ****************************************
	localparam logic [7:0] A_CTRL   = 8'h00;
	localparam logic [7:0] A_THRESH = 8'h04;
	localparam logic [7:0] A_FLOOR  = 8'h08;
	localparam logic [7:0] A_PVAL   = 8'h0C;
	localparam logic [7:0] A_SLEW   = 8'h10;
	localparam logic [7:0] A_OUT    = 8'h14;
	localparam logic [7:0] A_RAW    = 8'h18;
	localparam logic [7:0] A_WMAG   = 8'h1C;
	localparam logic [7:0] A_SMAG   = 8'h20;
	localparam int         CTRL_PRESET_BIT = 0;

	typedef enum logic [3:0] {
		RD_CTRL, RD_THRESH, RD_FLOOR, RD_PVAL, RD_SLEW,
		RD_OUT, RD_RAW, RD_WMAG, RD_SMAG, RD_NONE
	} rdiam_reg_t;

	// software settings
	typedef struct packed {
		logic        preset;
		logic [15:0] thresh;
		logic [15:0] floor;
		logic [15:0] pval;
		logic [15:0] slew_ms;
	} rdiam_cfg_t;

	// apb request from the master
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} rdiam_apb_req_t;

endpackage

// file: logic/rdiam_div.sv
`timescale 1ns/1ps

// restoring divider, one quotient bit per clock, 32 cycles
module rdiam_div import rdiam_pkg::*; (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// request
	input  wire logic        start,
	input  wire logic [31:0] numer,
	input  wire logic [15:0] denom,
	// answer
	output logic             busy,
	output logic             done,
	output logic [31:0]      quot
);

	typedef struct packed {
		logic        busy;
		logic        done;
		logic [4:0]  cnt;
		logic [16:0] rem;
		logic [31:0] quo;
		logic [15:0] den;
	} rdiam_div_st_t;

	rdiam_div_st_t s_q, s_d;
	logic [16:0]   trial;

	// ****************************************
	// iteration
	// ****************************************
	always_comb begin
		s_d    = s_q;
		trial  = 17'h00000;
		s_d.done = 1'b0;
		if (s_q.busy) begin
			trial     = {s_q.rem[15:0], s_q.quo[31]};
			s_d.quo   = {s_q.quo[30:0], 1'b0};
			if (trial >= {1'b0, s_q.den}) begin
				s_d.rem    = trial - {1'b0, s_q.den};
				s_d.quo[0] = 1'b1;
			end else begin
				s_d.rem = trial;
			end
			s_d.cnt = s_q.cnt + 5'h01;
			if (s_q.cnt == 5'h1F) begin
				s_d.busy = 1'b0;
				s_d.done = 1'b1;
			end
		end else if (start) begin
			s_d.busy = 1'b1;
			s_d.cnt  = 5'h00;
			s_d.rem  = 17'h00000;
			s_d.quo  = numer;
			s_d.den  = denom;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign busy = s_q.busy;
	assign done = s_q.done;
	assign quot = s_q.quo;

	// ****************************************
	// checks
	// ****************************************
	property p_div_latency;
		@(posedge clk) disable iff (!rst_n)
		(start && !busy) |-> ##33 done;
	endproperty
	a_div_latency: assert property (p_div_latency)
		else $error("divider did not finish in time");

	property p_div_exact;
		@(posedge clk) disable iff (!rst_n)
		(start && !busy && numer != 32'h0 && denom != 16'h0) |->
			##33 (quot == $past(numer, 33) / {16'h0000, $past(denom, 33)});
	endproperty
	a_div_exact: assert property (p_div_exact)
		else $error("divider quotient wrong");

endmodule

// file: dv/rdiam_spd_src.sv
`timescale 1ns/1ps

// ****************************************
// line speed source and reel feedback
// ****************************************
module rdiam_spd_src import rdiam_pkg::*; (
	// clock
	input  wire logic        clk,
	// wanted speeds
	input  wire logic [15:0] line_set,
	input  wire logic [15:0] reel_set,
	// speed pins
	output logic [15:0]      web_velocity_in,
	output logic [15:0]      spindle_velocity_in
);
	// both speeds move on the clock, like a sampled drive feedback
	always_ff @(posedge clk) begin
		web_velocity_in     <= line_set;
		spindle_velocity_in <= reel_set;
	end
endmodule

// file: dv/winder_roll_diameter_estimator_bench.sv
`timescale 1ns/1ps

module winder_roll_diameter_estimator_bench import rdiam_pkg::*; ;
	logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic pready, pslverr, act, er;
	logic [15:0] line_set = '0, reel_set = '0, wv, sv, o, r, wm, sm;
	int n_errors = 0, checked = 0;

	// ****************************************
	// design and speed source
	// ****************************************
	rdiam_spd_src i_rdiam_spd_src (.clk(clk), .line_set(line_set),
		.reel_set(reel_set), .web_velocity_in(wv),
		.spindle_velocity_in(sv));
	rdiam_est i_rdiam_est (.clk(clk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .pslverr(pslverr),
		.prdata(prdata), .web_velocity_in(wv),
		.spindle_velocity_in(sv), .roll_size_out(o),
		.roll_size_raw(r), .web_velocity_magnitude(wm),
		.spindle_velocity_magnitude(sm), .calc_active(act));

	always #10 clk = ~clk;

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %0h seen %0h", n, exp, seen);
		end
	endtask

	// one apb transfer; pready is waited for, never assumed
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rchk(logic [7:0] a, logic [31:0] exp);
		apb(1'b0, a, '0);
		chk("prdata", rd, exp);
		chk("pslverr", er, 1'b0);
	endtask

	// bounded wait for the output (w high) or raw diameter (w low)
	task automatic wait_eq(string n, bit w, logic [15:0] exp, int lim);
		int i;
		for (i = 0; i < lim && (w ? o : r) !== exp; i++)
			@(posedge clk);
		chk(n, w ? o : r, exp);
	endtask

	task automatic spd(int l, int s);
		line_set <= 16'(l);
		reel_set <= 16'(s);
		@(posedge clk);
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset;
		rchk(A_CTRL, 32'h0);
		rchk(A_THRESH, 32'h1F4);
		rchk(A_FLOOR, 32'h3E8);
		rchk(A_SLEW, 32'h1388);
		rchk(A_PVAL, 32'h0);
		apb(1'b1, A_OUT, 32'h1234);
		rchk(A_OUT, 32'h0);
		apb(1'b0, 8'h24, '0);
		chk("unmapped err", er, 1'b1);
		chk("unmapped data", rd, 32'h0);
		$display("test reset done");
	endtask

	// table of speed pairs, floor and expected diameter
	task automatic t_calc;
		int tl[6] = '{2000, -3000, 1500, 600, 9000, 30000};
		int ts[6] = '{1000, -1000, 1500, 32000, 0, 1000};
		int tf[6] = '{1000, 1000, 2000, 1000, 1000, 1000};
		int te[6] = '{2000, 3000, 2000, 1000, 10000, 10000};
		int k;
		apb(1'b1, A_SLEW, 32'h0);
		for (k = 0; k < 6; k++) begin
			apb(1'b1, A_FLOOR, 32'(tf[k]));
			spd(tl[k], ts[k]);
			// outlast any division started on the old speeds
			repeat (80) @(posedge clk);
			wait_eq("raw", 1'b0, 16'(te[k]), 300);
			chk("line mag", wm, 16'(tl[k] < 0 ? -tl[k] : tl[k]));
			chk("reel mag", sm, 16'(ts[k] < 0 ? -ts[k] : ts[k]));
			chk("active", act, 1'b1);
			wait_eq("out", 1'b1, 16'(te[k]), 12000);
			rchk(A_RAW, 32'(te[k]));
			rchk(A_OUT, 32'(te[k]));
			rchk(A_WMAG, 32'(tl[k] < 0 ? -tl[k] : tl[k]));
			rchk(A_SMAG, 32'(ts[k] < 0 ? -ts[k] : ts[k]));
		end
		apb(1'b1, A_FLOOR, 32'h3E8);
		$display("test calc done");
	endtask

	task automatic t_hold;
		spd(500, 2000);
		repeat (100) @(posedge clk);
		chk("active eq", act, 1'b0);
		chk("held raw", r, 16'h2710);
		spd(400, 2000);
		apb(1'b1, A_THRESH, 32'h12C);
		wait_eq("raw thr", 1'b0, 16'h03E8, 300);
		apb(1'b1, A_THRESH, 32'h1F4);
		$display("test hold done");
	endtask

	task automatic t_preset;
		logic [15:0] o1;
		spd(2000, 1000);
		apb(1'b1, A_PVAL, 32'h1B58);
		apb(1'b1, A_CTRL, 32'h1);
		repeat (3) @(posedge clk);
		chk("preset raw", r, 16'h1B58);
		chk("preset out", o, 16'h1B58);
		rchk(A_CTRL, 32'h1);
		apb(1'b1, A_SLEW, 32'h1);
		apb(1'b1, A_CTRL, 32'h0);
		wait_eq("raw after", 1'b0, 16'h07D0, 300);
		o1 = o;
		repeat (500) @(posedge clk);
		// 5 cycles per count at 1 ms, so about 100 counts
		chk("slew", (o1 - o >= 99) && (o1 - o <= 101), 1'b1);
		$display("test preset done");
	endtask

	// ****************************************
	// verdict, watchdog and main sequence
	// ****************************************
	task automatic final_report;
		$display("checked %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// tests need about 15000 cycles; a hang ends at 40000
	initial begin
		repeat (40000) @(posedge clk);
		n_errors++;
		final_report();
	end

	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk("reset out", o, 16'h0);
		t_reset();
		t_calc();
		t_hold();
		t_preset();
		final_report();
	end
endmodule
